// >>> hw/sec_regs.svh
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// register addresses
`define SEC_ADDR_SYS_EN 7'h04
`define SEC_ADDR_SUP_EN 7'h1C
`define SEC_ADDR_TRX_EN 7'h23
`define SEC_ADDR_WAKE_EN 7'h4C
`define SEC_ADDR_GLOBAL 7'h60
`define SEC_ADDR_SYS_ST 7'h61
`define SEC_ADDR_SUP_ST 7'h62
`define SEC_ADDR_TRX_ST 7'h63
`define SEC_ADDR_WAKE_ST 7'h64

// implemented bits per group, everything else reads zero
`define SEC_SYS_MASK 8'h06
`define SEC_SUP_MASK 8'h07
`define SEC_TRX_MASK 8'h33
`define SEC_WAKE_MASK 8'h03
`define SEC_GLOBAL_MASK 8'h0F

// reset values
`define SEC_EN_RST 8'h00
`define SEC_ST_RST 8'h00

// field positions
`define SEC_SYS_OTW_BIT 2
`define SEC_SYS_SPIF_BIT 1
`define SEC_SUP_OV_BIT 2
`define SEC_SUP_UV_BIT 1
`define SEC_SUP_MAIN_UV_BIT 0
`define SEC_TRX_FRAME_ERR_BIT 5
`define SEC_TRX_SILENCE_BIT 4
`define SEC_TRX_FAIL_BIT 1
`define SEC_TRX_WAKE_BIT 0
`define SEC_WAKE_RISE_BIT 1
`define SEC_WAKE_FALL_BIT 0

// bus silence timeout
`define SEC_SILENCE_TIME_US 1000
`define SEC_CLK_MHZ 125

`endif

// >>> hw/sec_pkg.sv
`default_nettype none
package sec_pkg;
  typedef logic [7:0] sec_byte_t;
  typedef logic [6:0] sec_addr_t;
  // bit position of each group in the global summary register
  typedef enum {SEC_GRP_SYS, SEC_GRP_SUP, SEC_GRP_TRX, SEC_GRP_WAKE} sec_group_e;
endpackage
`default_nettype wire

// >>> hw/sec_flag_bank.sv
`default_nettype none
module sec_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] captureEnable,
  input wire logic [WIDTH-1:0] setRequest,
  input wire logic clearWrite,
  input wire logic [WIDTH-1:0] clearData,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] clearBits;
  logic [WIDTH-1:0] setBits;
  logic [WIDTH-1:0] next_flags;

  // writing 0 leaves a flag alone
  assign clearBits = clearWrite ? clearData : '0;
  // disabled sources never reach the flag
  assign setBits = setRequest & captureEnable;
  // set after clear: an event in the clearing cycle survives
  assign next_flags = ((flags & ~clearBits) | setBits) & MASK;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule
`default_nettype wire

// >>> hw/sec_event_capture.sv
// How it works
// - supply status bit 2 at 62h latches when the auxiliary regulator reports overvoltage.
// - supply status bit 1 latches when the auxiliary regulator reports undervoltage.
// - supply status bit 0 latches on a main regulator 90 % undervoltage while it is on, never in Sleep.
// - main regulator undervoltage capture ignores the reset threshold selection entirely.
// - transceiver status bit 5 at 63h latches on a selective frame detection error.
// - transceiver status bit 4 sets after the silence timeout, armed only when enabled and after activity.
// - transceiver status bit 1 latches on transceiver deactivation, except in Sleep.
// - transceiver status bit 0 latches on a bus wake-up seen while the transceiver is offline.
// - wake status bit 1 at 64h latches on a rising edge of the wake input.
// - wake status bit 0 latches on a falling edge of the wake input.
// - system enable bit 1 gates capture of serial interface failures.
// - separate enable registers exist per group; system enable bit 2 gates overtemp warnings.
// - writing 1 clears a status flag and writing 0 does nothing.
// - the global register holds one bit per group, set while that group has a flag pending.
// - a Sleep command with any flag pending sends the device to Reset instead.
`include "sec_regs.svh"
`default_nettype none
module sec_event_capture #(
  parameter int SILENCE_CYCLES = `SEC_SILENCE_TIME_US * `SEC_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sec_pkg::sec_addr_t regAddr,
  input wire sec_pkg::sec_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output sec_pkg::sec_byte_t regRdData,
  input wire logic sleepMode,
  input wire logic overtempWarning,
  input wire logic serialFailure,
  input wire logic auxRegOvervoltage,
  input wire logic auxRegUndervoltage,
  input wire logic mainRegBelow90,
  input wire logic mainRegOn,
  input wire logic selectiveFrameError,
  input wire logic busActive,
  input wire logic transceiverFailure,
  input wire logic busWakeup,
  input wire logic transceiverOffline,
  input wire logic wakePin,
  input wire logic sleepCommand,
  output logic enterSleepMode,
  output logic enterResetMode,
  output logic eventPending
);
  import sec_pkg::*;

  localparam int CW = $clog2(SILENCE_CYCLES + 1);
  localparam logic [CW-1:0] SILENCE_LAST = CW'(SILENCE_CYCLES - 1);

  function automatic logic regHit(input sec_addr_t addr, input sec_addr_t target);
    regHit = (addr == target);
  endfunction

  sec_byte_t sysEnable;
  sec_byte_t supEnable;
  sec_byte_t trxEnable;
  sec_byte_t wakeEnable;
  sec_byte_t sysFlags;
  sec_byte_t supFlags;
  sec_byte_t trxFlags;
  sec_byte_t wakeFlags;
  sec_byte_t globalStatus;
  sec_byte_t sysSet;
  sec_byte_t supSet;
  sec_byte_t trxSet;
  sec_byte_t wakeSet;
  sec_byte_t readMux;
  logic wrSysEn, wrSupEn, wrTrxEn, wrWakeEn;
  logic wrSysSt, wrSupSt, wrTrxSt, wrWakeSt;
  logic wakePrev;
  logic wakeValid;
  logic wakeRise;
  logic wakeFall;
  logic silenceArmed;
  logic silenceHit;
  logic [CW-1:0] silenceCount;
  logic anyPending;

  // write decode
  assign wrSysEn = regWrEn && regHit(regAddr, `SEC_ADDR_SYS_EN);
  assign wrSupEn = regWrEn && regHit(regAddr, `SEC_ADDR_SUP_EN);
  assign wrTrxEn = regWrEn && regHit(regAddr, `SEC_ADDR_TRX_EN);
  assign wrWakeEn = regWrEn && regHit(regAddr, `SEC_ADDR_WAKE_EN);
  assign wrSysSt = regWrEn && regHit(regAddr, `SEC_ADDR_SYS_ST);
  assign wrSupSt = regWrEn && regHit(regAddr, `SEC_ADDR_SUP_ST);
  assign wrTrxSt = regWrEn && regHit(regAddr, `SEC_ADDR_TRX_ST);
  assign wrWakeSt = regWrEn && regHit(regAddr, `SEC_ADDR_WAKE_ST);

  // enable registers keep only their implemented bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sysEnable <= `SEC_EN_RST;
      supEnable <= `SEC_EN_RST;
      trxEnable <= `SEC_EN_RST;
      wakeEnable <= `SEC_EN_RST;
    end else begin
      if (wrSysEn) sysEnable <= regWrData & `SEC_SYS_MASK;
      if (wrSupEn) supEnable <= regWrData & `SEC_SUP_MASK;
      if (wrTrxEn) trxEnable <= regWrData & `SEC_TRX_MASK;
      if (wrWakeEn) wakeEnable <= regWrData & `SEC_WAKE_MASK;
    end
  end

  // wake input edges; first sample after reset only primes the history
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wakePrev <= 1'b0;
      wakeValid <= 1'b0;
    end else begin
      wakePrev <= wakePin;
      wakeValid <= 1'b1;
    end
  end
  assign wakeRise = wakeValid && wakePin && !wakePrev;
  assign wakeFall = wakeValid && !wakePin && wakePrev;

  // bus silence: arm on activity while enabled, time out after the quiet period
  assign silenceHit = silenceArmed && !busActive && (silenceCount == SILENCE_LAST);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      silenceArmed <= 1'b0;
      silenceCount <= '0;
    end else if (!trxEnable[`SEC_TRX_SILENCE_BIT]) begin
      silenceArmed <= 1'b0;
      silenceCount <= '0;
    end else if (busActive) begin
      silenceArmed <= 1'b1;
      silenceCount <= '0;
    end else if (silenceHit) begin
      silenceArmed <= 1'b0;
      silenceCount <= '0;
    end else if (silenceArmed) begin
      silenceCount <= silenceCount + CW'(1);
    end
  end

  // source conditions, bit-placed per group
  always_comb begin
    sysSet = '0;
    sysSet[`SEC_SYS_OTW_BIT] = overtempWarning && !sleepMode;
    sysSet[`SEC_SYS_SPIF_BIT] = serialFailure && !sleepMode;
    supSet = '0;
    supSet[`SEC_SUP_OV_BIT] = auxRegOvervoltage;
    supSet[`SEC_SUP_UV_BIT] = auxRegUndervoltage;
    // threshold selection never enters here: detection is fixed at 90 %
    supSet[`SEC_SUP_MAIN_UV_BIT] = mainRegBelow90 && mainRegOn && !sleepMode;
    trxSet = '0;
    trxSet[`SEC_TRX_FRAME_ERR_BIT] = selectiveFrameError;
    trxSet[`SEC_TRX_SILENCE_BIT] = silenceHit;
    trxSet[`SEC_TRX_FAIL_BIT] = transceiverFailure && !sleepMode;
    trxSet[`SEC_TRX_WAKE_BIT] = busWakeup && transceiverOffline;
    wakeSet = '0;
    wakeSet[`SEC_WAKE_RISE_BIT] = wakeRise;
    wakeSet[`SEC_WAKE_FALL_BIT] = wakeFall;
  end

  sec_flag_bank #(.WIDTH(8), .MASK(`SEC_SYS_MASK)) sysBank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .captureEnable(sysEnable),
    .setRequest(sysSet),
    .clearWrite(wrSysSt),
    .clearData(regWrData),
    .flags(sysFlags)
  );

  sec_flag_bank #(.WIDTH(8), .MASK(`SEC_SUP_MASK)) supBank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .captureEnable(supEnable),
    .setRequest(supSet),
    .clearWrite(wrSupSt),
    .clearData(regWrData),
    .flags(supFlags)
  );

  sec_flag_bank #(.WIDTH(8), .MASK(`SEC_TRX_MASK)) trxBank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .captureEnable(trxEnable),
    .setRequest(trxSet),
    .clearWrite(wrTrxSt),
    .clearData(regWrData),
    .flags(trxFlags)
  );

  sec_flag_bank #(.WIDTH(8), .MASK(`SEC_WAKE_MASK)) wakeBank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .captureEnable(wakeEnable),
    .setRequest(wakeSet),
    .clearWrite(wrWakeSt),
    .clearData(regWrData),
    .flags(wakeFlags)
  );

  // group summary
  always_comb begin
    globalStatus = '0;
    globalStatus[SEC_GRP_SYS] = |sysFlags;
    globalStatus[SEC_GRP_SUP] = |supFlags;
    globalStatus[SEC_GRP_TRX] = |trxFlags;
    globalStatus[SEC_GRP_WAKE] = |wakeFlags;
  end
  assign anyPending = |globalStatus;

  // read select; unmapped addresses read zero
  assign readMux =
    regHit(regAddr, `SEC_ADDR_SYS_EN) ? sysEnable :
    regHit(regAddr, `SEC_ADDR_SUP_EN) ? supEnable :
    regHit(regAddr, `SEC_ADDR_TRX_EN) ? trxEnable :
    regHit(regAddr, `SEC_ADDR_WAKE_EN) ? wakeEnable :
    regHit(regAddr, `SEC_ADDR_GLOBAL) ? globalStatus :
    regHit(regAddr, `SEC_ADDR_SYS_ST) ? sysFlags :
    regHit(regAddr, `SEC_ADDR_SUP_ST) ? supFlags :
    regHit(regAddr, `SEC_ADDR_TRX_ST) ? trxFlags :
    regHit(regAddr, `SEC_ADDR_WAKE_ST) ? wakeFlags : 8'h00;

  // read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= readMux;
    end
  end

  // sleep is refused while anything is pending, to avoid sleeping through an event
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      enterSleepMode <= 1'b0;
      enterResetMode <= 1'b0;
      eventPending <= 1'b0;
    end else begin
      enterSleepMode <= sleepCommand && !anyPending;
      enterResetMode <= sleepCommand && anyPending;
      eventPending <= anyPending;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sleepRefused;
    sleepCommand && anyPending;
  endsequence
  sequence s_resetTaken;
    enterResetMode && !enterSleepMode;
  endsequence

  a_aux_ov_capture: assert property (
    auxRegOvervoltage && supEnable[`SEC_SUP_OV_BIT] |=> supFlags[`SEC_SUP_OV_BIT])
    else $error("aux overvoltage not captured");
  a_aux_uv_capture: assert property (
    auxRegUndervoltage && supEnable[`SEC_SUP_UV_BIT] |=> supFlags[`SEC_SUP_UV_BIT])
    else $error("aux undervoltage not captured");
  a_main_uv_sleep: assert property (
    sleepMode && !supFlags[`SEC_SUP_MAIN_UV_BIT] |=> !supFlags[`SEC_SUP_MAIN_UV_BIT])
    else $error("main undervoltage captured in sleep");
  a_main_uv_capture: assert property (
    mainRegBelow90 && mainRegOn && !sleepMode && supEnable[`SEC_SUP_MAIN_UV_BIT]
    |=> supFlags[`SEC_SUP_MAIN_UV_BIT])
    else $error("main undervoltage not captured");
  a_frame_err_capture: assert property (
    selectiveFrameError && trxEnable[`SEC_TRX_FRAME_ERR_BIT] |=> trxFlags[`SEC_TRX_FRAME_ERR_BIT])
    else $error("frame error not captured");
  a_silence_unarmed: assert property (
    !silenceArmed && !trxFlags[`SEC_TRX_SILENCE_BIT] |=> !trxFlags[`SEC_TRX_SILENCE_BIT])
    else $error("silence flagged without prior activity");
  a_trx_fail_sleep: assert property (
    sleepMode && !trxFlags[`SEC_TRX_FAIL_BIT] |=> !trxFlags[`SEC_TRX_FAIL_BIT])
    else $error("transceiver failure captured in sleep");
  a_bus_wake_capture: assert property (
    busWakeup && transceiverOffline && trxEnable[`SEC_TRX_WAKE_BIT]
    |=> trxFlags[`SEC_TRX_WAKE_BIT])
    else $error("bus wake not captured");
  a_wake_rise_edge: assert property (
    wakeEnable[`SEC_WAKE_RISE_BIT] && wakeValid && $rose(wakePin)
    |=> wakeFlags[`SEC_WAKE_RISE_BIT])
    else $error("rising wake edge missed");
  a_wake_fall_edge: assert property (
    wakeEnable[`SEC_WAKE_FALL_BIT] && wakeValid && $fell(wakePin)
    |=> wakeFlags[`SEC_WAKE_FALL_BIT])
    else $error("falling wake edge missed");
  a_spif_gated: assert property (
    !sysEnable[`SEC_SYS_SPIF_BIT] && !sysFlags[`SEC_SYS_SPIF_BIT]
    |=> !sysFlags[`SEC_SYS_SPIF_BIT])
    else $error("serial failure set while disabled");
  a_otw_capture: assert property (
    overtempWarning && !sleepMode && sysEnable[`SEC_SYS_OTW_BIT] |=> sysFlags[`SEC_SYS_OTW_BIT])
    else $error("overtemp warning not captured");
  a_w1c_clear: assert property (
    wrWakeSt && regWrData[`SEC_WAKE_FALL_BIT] && !wakeSet[`SEC_WAKE_FALL_BIT]
    |=> !wakeFlags[`SEC_WAKE_FALL_BIT])
    else $error("write one did not clear");
  a_global_summary: assert property (
    globalStatus[SEC_GRP_TRX] == (trxFlags != 8'h00))
    else $error("global summary mismatch");
  a_sleep_refused: assert property (
    s_sleepRefused |=> s_resetTaken)
    else $error("sleep taken with event pending");
  a_flag_hold: assert property (
    supFlags[`SEC_SUP_OV_BIT] && !(wrSupSt && regWrData[`SEC_SUP_OV_BIT])
    |=> supFlags[`SEC_SUP_OV_BIT])
    else $error("flag dropped without clear");
  a_reserved_zero: assert property (
    (trxFlags & ~`SEC_TRX_MASK) == 8'h00 && (sysEnable & ~`SEC_SYS_MASK) == 8'h00)
    else $error("reserved bit set");
endmodule
`default_nettype wire

// >>> verification/sec_host_model.sv
`default_nettype none
module sec_host_model (
  input wire logic ref_clk,
  output var sec_pkg::sec_addr_t regAddr,
  output var sec_pkg::sec_byte_t regWrData,
  output var logic regWrEn,
  output var logic regRdEn,
  input wire sec_pkg::sec_byte_t regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;

  initial begin
    regAddr = 7'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // a status flag is cleared by a one in its bit, so callers pass exactly the bits to drop
  task wr(input sec_addr_t a, input sec_byte_t d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
    // released data is inverted so a stale value never looks like a fresh write
    regWrData = ~d;
    // idle edge so a following call never re-raises the strobe in the same time step
    @(posedge ref_clk);
    #1;
  endtask

  task rd(input sec_addr_t a, output sec_byte_t d);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
    d = regRdData;
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] src = 8'h00;
  logic sleepMode = 1'b0, mainRegOn = 1'b1, busActive = 1'b0;
  logic transceiverOffline = 1'b1, wakePin = 1'b0, sleepCommand = 1'b0;
  sec_addr_t regAddr;
  sec_byte_t regWrData, regRdData, rdValue;
  logic regWrEn, regRdEn, enterSleepMode, enterResetMode, eventPending;
  int errors = 0, num_checks = 0, sleepCount = 0, resetCount = 0;
  sec_addr_t allAddr [9] = '{7'h04, 7'h1C, 7'h23, 7'h4C, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64};
  sec_byte_t enMask [4] = '{8'h06, 8'h07, 8'h33, 8'h03};
  sec_addr_t srcAddr [8] = '{7'h61, 7'h61, 7'h62, 7'h62, 7'h62, 7'h63, 7'h63, 7'h63};
  int srcBit [8] = '{2, 1, 2, 1, 0, 5, 1, 0};
  int srcGrp [8] = '{0, 0, 1, 1, 1, 2, 2, 2};

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (enterSleepMode === 1'b1) sleepCount++;
    if (enterResetMode === 1'b1) resetCount++;
  end

  sec_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

  // short silence timeout keeps the run brief; expectations use the same figure
  sec_event_capture #(.SILENCE_CYCLES(20)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .sleepMode(sleepMode), .overtempWarning(src[0]),
    .serialFailure(src[1]), .auxRegOvervoltage(src[2]), .auxRegUndervoltage(src[3]),
    .mainRegBelow90(src[4]), .mainRegOn(mainRegOn), .selectiveFrameError(src[5]),
    .busActive(busActive), .transceiverFailure(src[6]), .busWakeup(src[7]),
    .transceiverOffline(transceiverOffline), .wakePin(wakePin),
    .sleepCommand(sleepCommand), .enterSleepMode(enterSleepMode),
    .enterResetMode(enterResetMode), .eventPending(eventPending));

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string name, input sec_byte_t exp, input sec_byte_t got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task rdchk(input sec_addr_t a, input sec_byte_t exp);
    host.rd(a, rdValue);
    chk($sformatf("register %h", a), exp, rdValue);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task pulse(input sec_byte_t m);
    src = m;
    cyc(1);
    src = 8'h00;
    cyc(1);
  endtask

  task sleep_req;
    sleepCommand = 1'b1;
    cyc(1);
    sleepCommand = 1'b0;
    cyc(3);
  endtask

  function automatic sec_byte_t bitv(input int b);
    return sec_byte_t'(8'h01 << b);
  endfunction

  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    cyc(12);
    reset_n = 1'b1;
    cyc(2);
    for (int i = 0; i < 9; i++) rdchk(allAddr[i], 8'h00);
    $display("test reset values done");
    pulse(8'hFF);
    wakePin = 1'b1;
    cyc(2);
    wakePin = 1'b0;
    cyc(2);
    for (int i = 4; i < 9; i++) rdchk(allAddr[i], 8'h00);
    $display("test disabled sources done");
    for (int i = 0; i < 4; i++) begin
      host.wr(allAddr[i], 8'hFF);
      rdchk(allAddr[i], enMask[i]);
    end
    host.wr(7'h60, 8'hFF);
    rdchk(7'h60, 8'h00);
    rdchk(7'h10, 8'h00);
    cyc(30);
    rdchk(7'h63, 8'h00);
    $display("test enables done");
    for (int i = 0; i < 8; i++) begin
      pulse(bitv(i));
      cyc(3);
      rdchk(srcAddr[i], bitv(srcBit[i]));
      rdchk(7'h60, bitv(srcGrp[i]));
      host.wr(srcAddr[i], 8'h00);
      rdchk(srcAddr[i], bitv(srcBit[i]));
      host.wr(srcAddr[i], bitv(srcBit[i]));
      rdchk(srcAddr[i], 8'h00);
    end
    $display("test capture and clear done");
    sleepMode = 1'b1;
    pulse(8'h53);
    sleepMode = 1'b0;
    mainRegOn = 1'b0;
    pulse(8'h10);
    mainRegOn = 1'b1;
    transceiverOffline = 1'b0;
    pulse(8'h80);
    transceiverOffline = 1'b1;
    cyc(2);
    rdchk(7'h61, 8'h00);
    rdchk(7'h62, 8'h00);
    rdchk(7'h63, 8'h00);
    $display("test blocked capture done");
    wakePin = 1'b1;
    cyc(2);
    rdchk(7'h64, 8'h02);
    host.wr(7'h64, 8'h02);
    wakePin = 1'b0;
    cyc(2);
    rdchk(7'h64, 8'h01);
    host.wr(7'h64, 8'h01);
    rdchk(7'h64, 8'h00);
    $display("test wake pin done");
    busActive = 1'b1;
    cyc(1);
    busActive = 1'b0;
    cyc(25);
    rdchk(7'h63, 8'h10);
    chk("event pending", 8'h01, {7'h00, eventPending});
    sleep_req();
    chk("reset entries", 8'h01, sec_byte_t'(resetCount));
    chk("sleep entries", 8'h00, sec_byte_t'(sleepCount));
    host.wr(7'h63, 8'h10);
    cyc(30);
    rdchk(7'h63, 8'h00);
    chk("event pending", 8'h00, {7'h00, eventPending});
    sleep_req();
    chk("sleep entries", 8'h01, sec_byte_t'(sleepCount));
    $display("test silence and sleep done");
    test_done();
  end
endmodule
`default_nettype wire
